// File: rtl/psdc_cfg.svh
`ifndef PSDC_CFG_SVH
`define PSDC_CFG_SVH
// strap vector layout: the latched snapshot and the loader override share it
`define PSDC_STRAP_W        7
`define PSDC_S_DUPLEX       0
`define PSDC_S_BACKPRESS    1
`define PSDC_S_FDFC         2
`define PSDC_S_MANFC        3
`define PSDC_S_AUTOX        4
`define PSDC_S_MANX         5
`define PSDC_S_XOVR         6
// tie-off for the manual crossover soft strap (straight mdi)
`define PSDC_MANX_TIEOFF    1'h0
// phy register bit positions
`define PSDC_BC_DUPLEX      8
`define PSDC_ADV_10FD       6
`define PSDC_ADV_PAUSE      10
// special mode codes chosen by duplex
`define PSDC_MODE_HALF      3'h0
`define PSDC_MODE_FULL      3'h1
// axi4-lite map
`define PSDC_A_STRAP        4'h0
`define PSDC_A_OVR          4'h4
`define PSDC_A_CTRL         4'h8
`define PSDC_A_DFLT         4'hC
`define PSDC_CTRL_OVR_VALID 0
`define PSDC_CTRL_RELOAD    1
`define PSDC_RESP_OKAY      2'h0
`define PSDC_RESP_DECERR    2'h3
`endif

// File: rtl/psdc_pkg.sv
package psdc_pkg;
`include "psdc_cfg.svh"
   typedef logic [`PSDC_STRAP_W-1:0] psdc_strap_type;
   typedef logic [2:0]               psdc_mode_type;
   // active-strap source selection
   typedef enum logic [1:0] {
      PSDC_SRC_IDLE   = 2'b00,
      PSDC_SRC_LATCH  = 2'b01,
      PSDC_SRC_LOADER = 2'b10
   } psdc_src_type;
endpackage : psdc_pkg

// File: rtl/psdc_if.sv
`timescale 1ns/1ns
// decoded defaults passed from the decoder to the top
interface psdc_if;
   logic                    fullDuplex;
   logic                    backpressEn;
   logic                    txPauseEn;
   logic                    rxPauseEn;
   logic                    manualFlowCtl;
   logic                    advPause;
   logic                    adv10Full;
   logic [2:0]              specialMode;
   logic                    autoCross;
   logic                    crossMdix;
   modport producer (output fullDuplex, backpressEn, txPauseEn, rxPauseEn, manualFlowCtl,
                     advPause, adv10Full, specialMode, autoCross, crossMdix);
   modport consumer (input fullDuplex, backpressEn, txPauseEn, rxPauseEn, manualFlowCtl,
                     advPause, adv10Full, specialMode, autoCross, crossMdix);
endinterface : psdc_if

// File: rtl/psdc_decode.sv
`timescale 1ns/1ns
`include "psdc_cfg.svh"
// pure decode of the active strap vector into register defaults
module psdc_decode (
   input  wire psdc_pkg::psdc_strap_type strap,
   psdc_if.producer                      dflt
);
   import psdc_pkg::*;

   // R1 duplex default
   assign dflt.fullDuplex    = strap[`PSDC_S_DUPLEX];
   // R2 duplex side effects
   assign dflt.adv10Full     = strap[`PSDC_S_DUPLEX];
   assign dflt.specialMode   = strap[`PSDC_S_DUPLEX] ? `PSDC_MODE_FULL : `PSDC_MODE_HALF;
   // R3 backpressure default
   assign dflt.backpressEn   = strap[`PSDC_S_BACKPRESS];
   // R4 R5 pause enables, only in manual mode
   assign dflt.txPauseEn     = strap[`PSDC_S_FDFC] & strap[`PSDC_S_MANFC];
   assign dflt.rxPauseEn     = strap[`PSDC_S_FDFC] & strap[`PSDC_S_MANFC];
   assign dflt.manualFlowCtl = strap[`PSDC_S_MANFC];
   // R6 R7 symmetric pause advert
   assign dflt.advPause      = ~strap[`PSDC_S_MANFC];
   // R8 R9 auto crossover gated by override
   assign dflt.autoCross     = ~strap[`PSDC_S_XOVR] & strap[`PSDC_S_AUTOX];
   // R10 manual crossover when auto off
   assign dflt.crossMdix     = ~strap[`PSDC_S_XOVR] & ~strap[`PSDC_S_AUTOX]
                               & strap[`PSDC_S_MANX];
endmodule : psdc_decode

// File: rtl/psdc_strap_top.sv
`timescale 1ns/1ns
`include "psdc_cfg.svh"
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// R1: the duplex strap gives the port 1 duplex default, low half and high full.
// R2: the duplex strap also sets basic-control duplex, advert bit 6 and the mode field.
// R3: the backpressure strap gives the port 1 backpressure enable default.
// R4: the full-duplex flow-control strap sets both transmit and receive pause enables.
// R5: the pause enables take effect only while manual flow control is selected.
// R6: manual select low uses negotiation and sets symmetric pause advert bit 10.
// R7: manual select high uses the pause enables and clears advert bit 10.
// R8: with override clear, port 2 auto crossover follows its strap.
// R9: with override set, the auto crossover strap has no effect.
// R10: auto strap low and override clear picks mdi on 0 and mdix on 1 from manual strap.
// R11: the manual crossover strap has no pin and ties to zero unless the loader overrides.
// R12: straps latch on reset release and loader values override them.
// R13: digital reset or reload restores latched values without re-sampling the pins; a loader pulse in the same cycle wins over both.
//////////////////////////////////////////////////////////////////////////////
module psdc_strap_top (
   input  wire logic                   clk,
   input  wire logic                   arst_n,
   input  wire logic                   pin_reset_n,
   input  wire logic                   digitalReset,
   input  wire logic                   p1DuplexInput,
   input  wire logic                   p1_backpressure_default_input,
   input  wire logic                   p1_fullduplex_flowctl_default_input,
   input  wire logic                   p1_manual_flowctl_select_input,
   input  wire logic                   p2AutoCrossInput,
   input  wire logic                   crossover_override_bit,
   input  wire logic                   loaderValid,
   input  wire psdc_pkg::psdc_strap_type loaderStraps,
   output logic                        phy_full_duplex_bit,
   output logic                        p1_backpressure_enable_bit,
   output logic                        p1_tx_pause_enable_bit,
   output logic                        p1_rx_pause_enable_bit,
   output logic                        p1_manual_flowctl_bit,
   output logic                        advSymPause,
   output logic                        adv10Full,
   output psdc_pkg::psdc_mode_type     phy_special_mode_reg,
   output logic                        p2AutoCross,
   output logic                        p2CrossMdix,
   output logic                        strapsLatched,
   input  wire logic [3:0]             s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [3:0]             s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready
);
   import psdc_pkg::*;

   //////////////////////////////////////////////////////////////////////////////
   // strap capture and selection state
   psdc_strap_type latch_q, latch_d;
   psdc_strap_type ovr_q, ovr_d;
   psdc_strap_type act_q, act_d;
   psdc_src_type   src_q, src_d;
   logic           ovrValid_q, ovrValid_d;
   logic           rstSeen_q, rstSeen_d;   // pin reset was low, capture on rising
   logic           reload;
   logic           swReload;
   logic           wrOvr;
   logic           wrCtrl;
   // held write word, declared here because the override path reads it
   logic [31:0]    wData_q, wData_d;
   psdc_strap_type pinStraps;

   // pins snapshot; manual crossover has no pin
   always_comb begin
      pinStraps = '0;
      pinStraps[`PSDC_S_DUPLEX]    = p1DuplexInput;
      pinStraps[`PSDC_S_BACKPRESS] = p1_backpressure_default_input;
      pinStraps[`PSDC_S_FDFC]      = p1_fullduplex_flowctl_default_input;
      pinStraps[`PSDC_S_MANFC]     = p1_manual_flowctl_select_input;
      pinStraps[`PSDC_S_AUTOX]     = p2AutoCrossInput;
      // R11 tie-off to mdi
      pinStraps[`PSDC_S_MANX]      = `PSDC_MANX_TIEOFF;
      // override bit is captured with the straps so the loader can also set it
      pinStraps[`PSDC_S_XOVR]      = crossover_override_bit;
   end

   // R13 digital reset and software reload share one restore path
   assign reload = digitalReset | swReload;

   // capture on first cycle after por or on pin reset release; a strap is a
   // level, so it is taken by a clocked process rather than the async reset
   always_comb begin
      latch_d    = latch_q;
      ovr_d      = ovr_q;
      act_d      = act_q;
      src_d      = src_q;
      ovrValid_d = ovrValid_q;
      rstSeen_d  = ~pin_reset_n;
      // R12 latch on reset release
      if (src_q == PSDC_SRC_IDLE || (rstSeen_q && pin_reset_n)) begin
         latch_d    = pinStraps;
         act_d      = pinStraps;
         src_d      = PSDC_SRC_LATCH;
         ovrValid_d = 1'b0;
      end else begin
         if (loaderValid) begin
            ovr_d      = loaderStraps;
            ovrValid_d = 1'b1;
         end else if (wrOvr) begin
            ovr_d = wData_q[`PSDC_STRAP_W-1:0];
         end
         // a loader pulse in the same cycle wins over the software control write
         if (wrCtrl && !loaderValid) begin
            ovrValid_d = wData_q[`PSDC_CTRL_OVR_VALID];
         end
         // R13 restore latched copy, pins not re-sampled
         if (reload && !loaderValid) begin
            ovrValid_d = 1'b0;
            act_d      = latch_q;
            src_d      = PSDC_SRC_LATCH;
         end else if (ovrValid_d) begin
            // R12 loader overrides latch
            act_d = ovr_d;
            src_d = PSDC_SRC_LOADER;
         end else begin
            act_d = latch_q;
            src_d = PSDC_SRC_LATCH;
         end
      end
      // pin reset held low keeps the snapshot idle
      if (!pin_reset_n) begin
         src_d = PSDC_SRC_IDLE;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         latch_q    <= '0;
         ovr_q      <= '0;
         act_q      <= '0;
         src_q      <= PSDC_SRC_IDLE;
         ovrValid_q <= 1'b0;
         rstSeen_q  <= 1'b0;
      end else begin
         latch_q    <= latch_d;
         ovr_q      <= ovr_d;
         act_q      <= act_d;
         src_q      <= src_d;
         ovrValid_q <= ovrValid_d;
         rstSeen_q  <= rstSeen_d;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // decode and output registers
   // decode is pure logic; every phy default output below is one register after act_q, strapsLatched comes straight from src_q
   psdc_if dflt ();

   psdc_decode u_decode (
      .strap (act_q),
      .dflt  (dflt.producer)
   );

   logic [11:0] out_q, out_d;

   // R1 to R10 defaults registered for clean outputs
   // the register costs one cycle of latency but keeps glitches off the phy defaults
   always_comb begin
      out_d = {dflt.fullDuplex, dflt.backpressEn, dflt.txPauseEn, dflt.rxPauseEn,
               dflt.manualFlowCtl, dflt.advPause, dflt.adv10Full, dflt.specialMode,
               dflt.autoCross, dflt.crossMdix};
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         out_q <= '0;
      end else begin
         out_q <= out_d;
      end
   end

   assign {phy_full_duplex_bit, p1_backpressure_enable_bit, p1_tx_pause_enable_bit,
           p1_rx_pause_enable_bit, p1_manual_flowctl_bit, advSymPause, adv10Full,
           phy_special_mode_reg, p2AutoCross, p2CrossMdix} = out_q;
   // stays low through a pin reset, so a fresh snapshot can be told apart
   assign strapsLatched = (src_q != PSDC_SRC_IDLE);

   //////////////////////////////////////////////////////////////////////////////
   // axi4-lite slave: one write and one read outstanding
   logic        awHeld_q, awHeld_d, wHeld_q, wHeld_d, bvalid_q, bvalid_d;
   logic [3:0]  awAddr_q, awAddr_d;
   logic [1:0]  bresp_q, bresp_d;
   logic        rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0]  rresp_q, rresp_d;
   logic        doWrite;
   logic        wStrb0_q, wStrb0_d;   // lane 0 strobe held with the data

   // used by the write response; the read side decodes in its own case
   function automatic logic addrMapped(input logic [3:0] a);
      addrMapped = (a == `PSDC_A_STRAP) || (a == `PSDC_A_OVR) ||
                   (a == `PSDC_A_CTRL) || (a == `PSDC_A_DFLT);
   endfunction : addrMapped

   // both write readies stay low while a response waits: one write at a time
   assign s_axi_awready = ~awHeld_q & ~bvalid_q;
   assign s_axi_wready  = ~wHeld_q & ~bvalid_q;
   assign s_axi_arready = ~rvalid_q;
   assign doWrite  = awHeld_q & wHeld_q & ~bvalid_q;
   // R12 software override: strobe and data come from the held copies, since
   // the master is free to drop the write channel once it has been taken
   assign wrOvr    = doWrite & (awAddr_q == `PSDC_A_OVR) & wStrb0_q;
   assign wrCtrl   = doWrite & (awAddr_q == `PSDC_A_CTRL) & wStrb0_q;
   // reload bit is not stored, so it reads back as zero and acts once
   assign swReload = wrCtrl & wData_q[`PSDC_CTRL_RELOAD];

   // write channel; override data comes from the held word
   always_comb begin
      awHeld_d = awHeld_q;
      wHeld_d  = wHeld_q;
      awAddr_d = awAddr_q;
      wData_d  = wData_q;
      wStrb0_d = wStrb0_q;
      bvalid_d = bvalid_q;
      bresp_d  = bresp_q;
      rvalid_d = rvalid_q;
      rdata_d  = rdata_q;
      rresp_d  = rresp_q;
      if (s_axi_awvalid && s_axi_awready) begin
         awHeld_d = 1'b1;
         // full address kept: a misaligned offset is unmapped and answers decerr
         awAddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wHeld_d = 1'b1;
         wData_d = s_axi_wdata;
         wStrb0_d = s_axi_wstrb[0];
      end
      if (doWrite) begin
         awHeld_d = 1'b0;
         wHeld_d  = 1'b0;
         bvalid_d = 1'b1;
         bresp_d  = addrMapped(awAddr_q) ? `PSDC_RESP_OKAY : `PSDC_RESP_DECERR;
      end else if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      // read: state and defaults visible to software
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_d = 1'b1;
         rresp_d  = `PSDC_RESP_OKAY;
         rdata_d  = '0;
         // misaligned read offsets fall to the default and answer decerr
         unique case (s_axi_araddr)
            `PSDC_A_STRAP: rdata_d[`PSDC_STRAP_W-1:0] = latch_q;
            `PSDC_A_OVR:   rdata_d[`PSDC_STRAP_W-1:0] = ovr_q;
            `PSDC_A_CTRL:  rdata_d[`PSDC_CTRL_OVR_VALID] = ovrValid_q;
            `PSDC_A_DFLT:  rdata_d[11:0] = out_q;
            default:       rresp_d = `PSDC_RESP_DECERR;
         endcase
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         awHeld_q <= 1'b0;
         wHeld_q  <= 1'b0;
         awAddr_q <= '0;
         wData_q  <= '0;
         wStrb0_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q  <= '0;
         rvalid_q <= 1'b0;
         rdata_q  <= '0;
         rresp_q  <= '0;
      end else begin
         awHeld_q <= awHeld_d;
         wHeld_q  <= wHeld_d;
         awAddr_q <= awAddr_d;
         wData_q  <= wData_d;
         wStrb0_q <= wStrb0_d;
         bvalid_q <= bvalid_d;
         bresp_q  <= bresp_d;
         rvalid_q <= rvalid_d;
         rdata_q  <= rdata_d;
         rresp_q  <= rresp_d;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata  = rdata_q;
   assign s_axi_rresp  = rresp_q;

endmodule : psdc_strap_top

// File: verification/psdc_strap_properties.sv
`timescale 1ns/1ns
`include "psdc_cfg.svh"
//////////////////////////////////////////////////////////////////////////////
// relations between the decoded defaults, the snapshot and the bus answers
module psdc_strap_checker (
   input wire logic                    clk,
   input wire logic                    arst_n,
   input wire logic                    strapsLatched,
   input wire logic                    p1DuplexInput,
   input wire logic                    p1_backpressure_default_input,
   input wire logic                    phy_full_duplex_bit,
   input wire logic                    p1_backpressure_enable_bit,
   input wire logic                    p1_tx_pause_enable_bit,
   input wire logic                    p1_rx_pause_enable_bit,
   input wire logic                    p1_manual_flowctl_bit,
   input wire logic                    advSymPause,
   input wire logic                    adv10Full,
   input wire psdc_pkg::psdc_mode_type phy_special_mode_reg,
   input wire logic                    s_axi_bvalid,
   input wire logic                    s_axi_bready,
   input wire logic                    s_axi_rvalid,
   input wire logic                    s_axi_rready,
   input wire logic [31:0]             s_axi_rdata
);
   import psdc_pkg::*;
   logic [1:0] settleQ;
   logic [1:0] settleD;
   logic       settled;
   // snapshot age; decode lags capture, so relations wait for it to settle
   always_comb begin
      settleD = settleQ;
      if (!strapsLatched) settleD = 2'h0;
      else if (settleQ != 2'h3) settleD = settleQ + 2'h1;
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) settleQ <= 2'h0;
      else settleQ <= settleD;
   end
   assign settled = (settleQ == 2'h3);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence snapTaken;
      $rose(strapsLatched);
   endsequence
   sequence writeWaiting;
      s_axi_bvalid && !s_axi_bready;
   endsequence
   dup_capture_a: assert property (snapTaken |-> ##2 phy_full_duplex_bit == $past(p1DuplexInput, 3))
      else $error("duplex default differs from captured pin");
   bp_capture_a: assert property (snapTaken |-> ##2
      p1_backpressure_enable_bit == $past(p1_backpressure_default_input, 3))
      else $error("backpressure default differs from captured pin");
   mode_duplex_a: assert property (settled |-> adv10Full == phy_full_duplex_bit &&
      phy_special_mode_reg == (phy_full_duplex_bit ? `PSDC_MODE_FULL : `PSDC_MODE_HALF))
      else $error("advert bit or mode field disagrees with duplex");
   pause_pair_a: assert property (settled |-> p1_tx_pause_enable_bit == p1_rx_pause_enable_bit)
      else $error("transmit and receive pause enables differ");
   pause_gate_a: assert property (settled && !p1_manual_flowctl_bit |->
      !p1_tx_pause_enable_bit && !p1_rx_pause_enable_bit)
      else $error("pause enable applied without manual select");
   pause_advert_a: assert property (settled |-> advSymPause != p1_manual_flowctl_bit)
      else $error("symmetric pause advert not inverse of manual select");
   bresp_hold_a: assert property (writeWaiting |=> s_axi_bvalid)
      else $error("write response dropped before taken");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held until taken");
endmodule : psdc_strap_checker
//////////////////////////////////////////////////////////////////////////////
bind psdc_strap_top psdc_strap_checker i_chk (.clk, .arst_n, .strapsLatched, .p1DuplexInput,
   .p1_backpressure_default_input, .phy_full_duplex_bit, .p1_backpressure_enable_bit,
   .p1_tx_pause_enable_bit, .p1_rx_pause_enable_bit, .p1_manual_flowctl_bit, .advSymPause,
   .adv10Full, .phy_special_mode_reg, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid,
   .s_axi_rready, .s_axi_rdata);

// File: verification/psdc_strap_source.sv
`timescale 1ns/1ns
// strap pins and the configuration loader in front of the block
module psdc_strap_source (
   input  wire logic                   clk,
   output psdc_pkg::psdc_strap_type    pinVec,
   output logic                        loaderValid,
   output psdc_pkg::psdc_strap_type    loaderStraps
);
   import psdc_pkg::*;
   initial begin
      pinVec = 7'h00;
      loaderValid = 1'b0;
      loaderStraps = 7'h55;
   end
   // manual crossover has no pin, so its lane is never driven high
   task automatic setPins(input psdc_strap_type v);
      @(posedge clk);
      pinVec <= v & 7'h5F;
   endtask : setPins
   // loader pulse overrides; idle lanes show garbage so stale data never counts
   task automatic load(input psdc_strap_type v);
      @(posedge clk);
      loaderValid <= 1'b1;
      loaderStraps <= v;
      @(posedge clk);
      loaderValid <= 1'b0;
      loaderStraps <= ~v;
   endtask : load
endmodule : psdc_strap_source

// File: verification/test_port_strap_default_config.sv
`timescale 1ns/1ns
`include "psdc_cfg.svh"
module test_port_strap_default_config;
   import psdc_pkg::*;
   logic clk = 0, arst_n = 0, pinRstN = 1, digitalReset = 0;
   logic [3:0] awAddr = 0, arAddr = 0, wStrb = 4'hF;
   logic awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
   logic awReady, wReady, bValid, arReady, rValid, latched, loadValid;
   logic [31:0] wData = 0, rData, got;
   logic [1:0] bResp, rResp;
   logic [11:0] outVec;
   psdc_strap_type pins, loadVec;
   int mismatches = 0, nTests = 0, cycles = 0;
   always #5 clk = ~clk;
   psdc_strap_source i_src (.clk(clk), .pinVec(pins), .loaderValid(loadValid),
      .loaderStraps(loadVec));
   psdc_strap_top i_dut (.clk(clk), .arst_n(arst_n), .pin_reset_n(pinRstN),
      .digitalReset(digitalReset), .p1DuplexInput(pins[0]),
      .p1_backpressure_default_input(pins[1]), .p1_fullduplex_flowctl_default_input(pins[2]),
      .p1_manual_flowctl_select_input(pins[3]), .p2AutoCrossInput(pins[4]),
      .crossover_override_bit(pins[6]), .loaderValid(loadValid), .loaderStraps(loadVec),
      .phy_full_duplex_bit(outVec[11]), .p1_backpressure_enable_bit(outVec[10]),
      .p1_tx_pause_enable_bit(outVec[9]), .p1_rx_pause_enable_bit(outVec[8]),
      .p1_manual_flowctl_bit(outVec[7]), .advSymPause(outVec[6]), .adv10Full(outVec[5]),
      .phy_special_mode_reg(outVec[4:2]), .p2AutoCross(outVec[1]), .p2CrossMdix(outVec[0]),
      .strapsLatched(latched), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
      .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
      .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
      .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
      .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
      .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady));
   //////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", nTests, mismatches);
      if (mismatches == 0 && nTests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : conclude
   // a hang anywhere ends the run through the same report
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         conclude();
      end
   end
   task automatic checkVal(input logic [31:0] g, input logic [31:0] e, input string what);
      nTests++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %0t %s got %h exp %h", $time, what, g, e);
      end
   endtask : checkVal
   // defaults expected from a strap vector, crossover override included
   function automatic logic [11:0] decoded(input psdc_strap_type s);
      logic m;
      m = s[`PSDC_S_MANFC];
      return {s[0], s[1], s[2] & m, s[2] & m, m, ~m, s[0],
              s[0] ? `PSDC_MODE_FULL : `PSDC_MODE_HALF, s[4] & ~s[6], ~s[4] & ~s[6] & s[5]};
   endfunction : decoded
   task automatic checkOut(input psdc_strap_type s);
      repeat (4) @(posedge clk);
      checkVal({20'h0, outVec}, {20'h0, decoded(s)}, "defaults");
   endtask : checkOut
   // address and data offered together, each dropped once taken; bready raised late
   task automatic axiWrite(input logic [3:0] a, input logic [31:0] d);
      logic awP, wP;
      awP = 1;
      wP = 1;
      awAddr <= a;
      wData <= d;
      awValid <= 1'b1;
      wValid <= 1'b1;
      while (awP || wP) begin
         @(posedge clk);
         if (awP && awReady) begin awP = 0; awValid <= 1'b0; end
         if (wP && wReady) begin wP = 0; wValid <= 1'b0; end
      end
      @(posedge clk);
      bReady <= 1'b1;
      do @(posedge clk); while (!bValid);
      bReady <= 1'b0;
      checkVal({30'h0, bResp}, {30'h0, `PSDC_RESP_OKAY}, "write response");
   endtask : axiWrite
   task automatic axiRead(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      arAddr <= a;
      arValid <= 1'b1;
      do @(posedge clk); while (!arReady);
      arValid <= 1'b0;
      @(posedge clk);
      rReady <= 1'b1;
      do @(posedge clk); while (!rValid);
      d = rData;
      r = rResp;
      rReady <= 1'b0;
   endtask : axiRead
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [1:0] resp;
      i_src.setPins(7'h0D);
      @(posedge clk);
      arst_n <= 1'b1;
      do @(posedge clk); while (!latched);
      checkOut(7'h0D);
      axiRead(`PSDC_A_STRAP, got, resp);
      checkVal(got, 32'h0D, "snapshot");
      i_src.setPins(7'h72);
      checkOut(7'h0D);
      i_src.load(7'h26);
      checkOut(7'h26);
      i_src.load(7'h30);
      checkOut(7'h30);
      i_src.load(7'h50);
      checkOut(7'h50);
      i_src.load(7'h60);
      checkOut(7'h60);
      digitalReset <= 1'b1;
      @(posedge clk);
      digitalReset <= 1'b0;
      checkOut(7'h0D);
      axiWrite(`PSDC_A_OVR, 32'h1);
      axiWrite(`PSDC_A_CTRL, 32'h1);
      checkOut(7'h01);
      axiRead(`PSDC_A_CTRL, got, resp);
      checkVal(got, 32'h1, "override valid");
      axiRead(`PSDC_A_DFLT, got, resp);
      checkVal(got, {20'h0, decoded(7'h01)}, "defaults word");
      wStrb <= 4'hE;
      axiWrite(`PSDC_A_OVR, 32'h7F);
      wStrb <= 4'hF;
      axiRead(`PSDC_A_OVR, got, resp);
      checkVal(got, 32'h1, "lane 0 strobe low ignored");
      axiWrite(`PSDC_A_CTRL, 32'h2);
      checkOut(7'h0D);
      axiRead(4'h2, got, resp);
      checkVal({30'h0, resp}, {30'h0, `PSDC_RESP_DECERR}, "unmapped read");
      pinRstN <= 1'b0;
      repeat (2) @(posedge clk);
      pinRstN <= 1'b1;
      checkOut(7'h52);
      axiRead(`PSDC_A_STRAP, got, resp);
      checkVal(got, 32'h52, "snapshot after pin reset");
      conclude();
   end
endmodule : test_port_strap_default_config
